// >>> hdl/cmpc_pkg.sv
package cmpc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry and register indices (byte address = index * 4)
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_CORE_INT_CTRL = 8'h0B;
    localparam logic [7:0] IDX_PERIPH_FLAGS  = 8'h0C;
    localparam logic [7:0] IDX_COMP_CTRL     = 8'h1F;
    localparam logic [7:0] IDX_PORT_A_DIR    = 8'h85;
    localparam logic [7:0] IDX_PERIPH_ENABLE = 8'h8C;
    localparam logic [7:0] IDX_PORT_A_DATA   = 8'h05;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_GLOBAL_IRQ_EN  = 7;
    localparam int BIT_PERIPH_IRQ_EN  = 6;
    localparam int BIT_CHANGE_FLAG    = 6;
    localparam int BIT_CHANGE_ENABLE  = 6;
    localparam int BIT_SECOND_RESULT  = 7;
    localparam int BIT_FIRST_RESULT   = 6;
    localparam int BIT_SECOND_INVERT  = 5;
    localparam int BIT_FIRST_INVERT   = 4;
    localparam int BIT_INPUT_SWITCH   = 3;
    localparam int PIN_FIRST_ROUTE    = 3;
    localparam int PIN_SECOND_ROUTE   = 4;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [5:0] RST_COMP_CTRL  = 6'h00;
    localparam logic [7:0] RST_INT_CTRL   = 8'h00;
    localparam logic [7:0] RST_PORT_DIR   = 8'hFF;
    localparam logic [7:0] RST_PORT_LATCH = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Comparator modes and analog pin mask per mode (index = mode)
    localparam logic [2:0] MODE_RESET     = 3'h0;
    localparam logic [2:0] MODE_ROUTE_ONE = 3'h1;
    localparam logic [2:0] MODE_ROUTE_TWO = 3'h6;
    localparam logic [2:0] MODE_OFF       = 3'h7;
    localparam logic [7:0][7:0] ANALOG_MASK = {
        8'h00, 8'h07, 8'h06, 8'h0F, 8'h07, 8'h0F, 8'h07, 8'h0F};

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } cmpc_avm_req_t;

    typedef struct packed {
        logic       waitReq;
        logic [7:0] readData;
        logic [5:0] compCtrl;
        logic [7:0] coreIntCtrl;
        logic       compareChangeFlag;
        logic       compareChangeEnable;
        logic [7:0] portADirection;
        logic [7:0] portLatch;
        logic [1:0] powerDown;
        logic [1:0] latchedResult;
        logic [1:0] aboveS1;
        logic [1:0] aboveS2;
        logic [1:0] aboveS3;
        logic [1:0] aboveOk;
        logic [7:0] pinS1;
        logic [7:0] pinS2;
        logic [7:0] pinS3;
        logic [7:0] pinOk;
        logic       irqRequest;
        logic       wakeRequest;
    } cmpc_state_t;

    localparam cmpc_state_t STATE_RESET = '{
        waitReq:        1'b1,
        compCtrl:       RST_COMP_CTRL,
        coreIntCtrl:    RST_INT_CTRL,
        portADirection: RST_PORT_DIR,
        portLatch:      RST_PORT_LATCH,
        powerDown:      2'h3,
        default:        '0};

endpackage

// >>> hdl/cmpc_comparator_ctrl.sv
// Overview of operation
// - Results of comparators two and one read at bits 7:6, read-only.
// - Modes 110 and 001 put raw comparator results on pins 3 and 4.
// - Port direction bits still enable those pin drivers while routed.
// - Port data reads return zero on pins that the mode makes analog.
// - Change flag sets whenever either result differs from latched copy.
// - Change flag is bit 6 of peripheral flags; writable 0 or 1.
// - Interrupt requested only with change, peripheral and global enables.
// - Flag still sets while any enable is clear; only request suppressed.
// - A change coinciding with a control register read still sets the flag.
// - Any control register access latches both present results.
// - Persisting mismatch keeps setting the flag, defeating a clear.
// - Comparators and their interrupt keep working in sleep; may wake.
// - Mode 111 switches both comparators off.
// - Waking from sleep leaves the control register unchanged.
// - Reset loads control register with zero, mode 000, pins analog.
// - Both comparators stay powered down throughout reset.
// - Comparator result high when positive input exceeds negative.
// - Per-comparator invert bit inverts reported and routed result.
`timescale 1ns/1ps
`default_nettype none

module cmpc_comparator_ctrl (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire cmpc_pkg::cmpc_avm_req_t busReq,
    output logic [31:0]                busReadData,
    output logic                       busWaitRequest,
    input  wire logic [1:0]            compAbove,
    output logic [1:0]                 compPowerDown,
    output logic [2:0]                 compMode,
    output logic                       compInputSwitch,
    input  wire logic [7:0]            portIn,
    output logic [7:0]                 portOut,
    output logic [7:0]                 portOutEnN,
    output logic                       irqRequest,
    output logic                       wakeRequest
);

    ////////////////////////////////////////////////////////////////////////
    // State and decoded views
    cmpc_pkg::cmpc_state_t st;
    cmpc_pkg::cmpc_state_t next_st;

    logic       reqActive;
    logic [7:0] regIdx;
    logic       commit;
    logic       wrLane0;
    logic [2:0] modeField;
    logic [1:0] invertBits;
    logic [1:0] compResult;
    logic [1:0] rawResult;
    logic       routeMode;
    logic [7:0] readValue;

    // Request decode: index is the word part of the byte address
    assign reqActive = busReq.read | busReq.write;
    assign regIdx    = busReq.address[cmpc_pkg::ADDR_W-1:2];
    assign commit    = reqActive & ~st.waitReq;
    assign wrLane0   = commit & busReq.write & busReq.byteenable[0];

    // Control fields
    assign modeField  = st.compCtrl[2:0];
    assign invertBits = {st.compCtrl[cmpc_pkg::BIT_SECOND_INVERT],
                         st.compCtrl[cmpc_pkg::BIT_FIRST_INVERT]};
    assign routeMode  = (modeField == cmpc_pkg::MODE_ROUTE_ONE) ||
                        (modeField == cmpc_pkg::MODE_ROUTE_TWO);

    // Synchronised result, inverted, forced low while powered down
    assign compResult = (st.aboveOk ^ invertBits) & ~st.powerDown;
    // Unsynchronised result for pin routing
    assign rawResult  = compAbove ^ invertBits;

    ////////////////////////////////////////////////////////////////////////
    // Read value mux
    always_comb begin
        readValue = 8'h00;
        if (regIdx == cmpc_pkg::IDX_COMP_CTRL) begin
            readValue = {compResult, st.compCtrl};
        end else if (regIdx == cmpc_pkg::IDX_CORE_INT_CTRL) begin
            readValue = st.coreIntCtrl;
        end else if (regIdx == cmpc_pkg::IDX_PERIPH_FLAGS) begin
            readValue[cmpc_pkg::BIT_CHANGE_FLAG] = st.compareChangeFlag;
        end else if (regIdx == cmpc_pkg::IDX_PERIPH_ENABLE) begin
            readValue[cmpc_pkg::BIT_CHANGE_ENABLE] = st.compareChangeEnable;
        end else if (regIdx == cmpc_pkg::IDX_PORT_A_DIR) begin
            readValue = st.portADirection;
        end else if (regIdx == cmpc_pkg::IDX_PORT_A_DATA) begin
            // Analog pins read as zero
            readValue = st.pinOk & ~cmpc_pkg::ANALOG_MASK[modeField];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_st = st;

        // Three-stage input capture; accept once stages two and three agree
        next_st.aboveS1 = compAbove;
        next_st.aboveS2 = st.aboveS1;
        next_st.aboveS3 = st.aboveS2;
        if (st.aboveS2 == st.aboveS3) begin
            next_st.aboveOk = st.aboveS3;
        end
        next_st.pinS1 = portIn;
        next_st.pinS2 = st.pinS1;
        next_st.pinS3 = st.pinS2;
        if (st.pinS2 == st.pinS3) begin
            next_st.pinOk = st.pinS3;
        end

        // Bus handshake: first edge loads read data, second commits
        if (reqActive && st.waitReq) begin
            next_st.waitReq  = 1'b0;
            next_st.readData = readValue;
        end else if (!st.waitReq) begin
            next_st.waitReq = 1'b1;
        end

        // Register writes, low byte lane only
        if (wrLane0) begin
            if (regIdx == cmpc_pkg::IDX_COMP_CTRL) begin
                // Result bits are not stored, so writes there vanish
                next_st.compCtrl = busReq.writedata[5:0];
            end else if (regIdx == cmpc_pkg::IDX_CORE_INT_CTRL) begin
                next_st.coreIntCtrl = busReq.writedata[7:0];
            end else if (regIdx == cmpc_pkg::IDX_PERIPH_FLAGS) begin
                next_st.compareChangeFlag =
                    busReq.writedata[cmpc_pkg::BIT_CHANGE_FLAG];
            end else if (regIdx == cmpc_pkg::IDX_PERIPH_ENABLE) begin
                next_st.compareChangeEnable =
                    busReq.writedata[cmpc_pkg::BIT_CHANGE_ENABLE];
            end else if (regIdx == cmpc_pkg::IDX_PORT_A_DIR) begin
                next_st.portADirection = busReq.writedata[7:0];
            end else if (regIdx == cmpc_pkg::IDX_PORT_A_DATA) begin
                next_st.portLatch = busReq.writedata[7:0];
            end
        end

        // Any access to the control register re-arms change detection;
        // the flag logic below still sees this cycle's mismatch
        if (commit && regIdx == cmpc_pkg::IDX_COMP_CTRL) begin
            next_st.latchedResult = compResult;
        end

        // Mismatch sets the flag regardless of enables; set beats clear
        if (compResult != st.latchedResult) begin
            next_st.compareChangeFlag = 1'b1;
        end

        // Comparators off in reset mode and in mode 111
        if (modeField == cmpc_pkg::MODE_OFF ||
            modeField == cmpc_pkg::MODE_RESET) begin
            next_st.powerDown = 2'h3;
        end else begin
            next_st.powerDown = 2'h0;
        end

        // Interrupt request needs all three enables
        next_st.irqRequest = st.compareChangeFlag &
            st.compareChangeEnable &
            st.coreIntCtrl[cmpc_pkg::BIT_PERIPH_IRQ_EN] &
            st.coreIntCtrl[cmpc_pkg::BIT_GLOBAL_IRQ_EN];
        // Wake needs only the comparator enable; logic runs on in sleep
        next_st.wakeRequest = st.compareChangeFlag &
            st.compareChangeEnable;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset loads control zero and powers down
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= cmpc_pkg::STATE_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign busReadData     = {24'h000000, st.readData};
    assign busWaitRequest  = st.waitReq;
    assign compPowerDown   = st.powerDown;
    assign compMode        = modeField;
    assign compInputSwitch = st.compCtrl[cmpc_pkg::BIT_INPUT_SWITCH];
    assign irqRequest      = st.irqRequest;
    assign wakeRequest     = st.wakeRequest;
    // Direction bits drive the enables in every mode
    assign portOutEnN      = st.portADirection;

    // Pin data: routed pins take the raw result in modes 110 and 001
    always_comb begin
        portOut = st.portLatch;
        if (routeMode) begin
            portOut[cmpc_pkg::PIN_FIRST_ROUTE]  = rawResult[0];
            portOut[cmpc_pkg::PIN_SECOND_ROUTE] = rawResult[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_result_readback: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && reqActive && st.waitReq && busReq.read &&
         regIdx == cmpc_pkg::IDX_COMP_CTRL)
        |=> busReadData[7:6] == $past(compResult))
        else $error("control read did not return current results");

    a_route_pins: assert property (
        @(posedge core_clk) disable iff (rst)
        (modeField == cmpc_pkg::MODE_ROUTE_ONE ||
         modeField == cmpc_pkg::MODE_ROUTE_TWO)
        |-> (portOut[4:3] == (compAbove ^ invertBits)))
        else $error("routed pins do not follow raw results");

    a_direction_enable: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && wrLane0 && regIdx == cmpc_pkg::IDX_PORT_A_DIR)
        |=> portOutEnN == $past(busReq.writedata[7:0]))
        else $error("direction write did not reach pin enables");

    a_analog_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && reqActive && st.waitReq &&
         regIdx == cmpc_pkg::IDX_PORT_A_DATA)
        |=> (busReadData[7:0] &
             cmpc_pkg::ANALOG_MASK[$past(modeField)]) == 8'h00)
        else $error("analog pin read nonzero");

    a_flag_on_change: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && compResult != st.latchedResult) |=> st.compareChangeFlag)
        else $error("change did not set flag");

    a_flag_sw_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && wrLane0 && regIdx == cmpc_pkg::IDX_PERIPH_FLAGS &&
         compResult == st.latchedResult)
        |=> st.compareChangeFlag == $past(busReq.writedata[6]))
        else $error("flag write not honoured");

    a_irq_gating: assert property (
        @(posedge core_clk) disable iff (rst)
        ce |=> irqRequest == $past(st.compareChangeFlag &
            st.compareChangeEnable & st.coreIntCtrl[6] & st.coreIntCtrl[7]))
        else $error("interrupt request gating wrong");

    a_flag_disabled: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && !st.compareChangeEnable && compResult != st.latchedResult)
        |=> st.compareChangeFlag && !irqRequest)
        else $error("flag not set or request leaked while disabled");

    a_access_latches: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && commit && regIdx == cmpc_pkg::IDX_COMP_CTRL)
        |=> st.latchedResult == $past(compResult))
        else $error("control access did not latch results");

    a_mode_off: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && modeField == cmpc_pkg::MODE_OFF) |=> compPowerDown == 2'h3)
        else $error("mode 111 did not power down");

    a_reset_state: assert property (
        @(posedge core_clk)
        rst |=> (st.compCtrl == 6'h00 && compPowerDown == 2'h3 &&
                 busWaitRequest))
        else $error("reset did not clear control");

    a_bus_answer: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && reqActive && st.waitReq) |=> !busWaitRequest)
        else $error("bus request not answered in one cycle");

    // Waitrequest stays low for one cycle only
    a_wait_one_cycle: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && !busWaitRequest) |=> busWaitRequest)
        else $error("waitrequest held low too long");

    // Control writes keep only the low six bits
    a_ctrl_write_low: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && wrLane0 && regIdx == cmpc_pkg::IDX_COMP_CTRL)
        |=> st.compCtrl == $past(busReq.writedata[5:0]))
        else $error("control write not stored");

    // Outside the routed modes every pin shows the port latch
    a_latch_on_pins: assert property (
        @(posedge core_clk) disable iff (rst)
        !routeMode |-> portOut == st.portLatch)
        else $error("pins do not follow port latch");

    // Routed modes replace only the two result pins
    a_route_only_two: assert property (
        @(posedge core_clk) disable iff (rst)
        routeMode |-> (portOut[7:5] == st.portLatch[7:5] &&
                       portOut[2:0] == st.portLatch[2:0]))
        else $error("routing disturbed other pins");

    // Direction bits gate the drivers in the routed modes too
    a_dir_gates_pins: assert property (
        @(posedge core_clk) disable iff (rst)
        routeMode |-> portOutEnN == st.portADirection)
        else $error("routed pins ignore direction bits");

    // A clearing write loses to a persisting mismatch
    a_set_beats_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && wrLane0 && regIdx == cmpc_pkg::IDX_PERIPH_FLAGS &&
         compResult != st.latchedResult)
        |=> st.compareChangeFlag)
        else $error("clear won over a persisting mismatch");

    // Writing one sets the flag as a simulated interrupt
    a_flag_write_one: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && wrLane0 && regIdx == cmpc_pkg::IDX_PERIPH_FLAGS &&
         busReq.writedata[cmpc_pkg::BIT_CHANGE_FLAG])
        |=> st.compareChangeFlag)
        else $error("flag write of one ignored");

    // No request while the global enable is clear
    a_global_gate: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && !st.coreIntCtrl[cmpc_pkg::BIT_GLOBAL_IRQ_EN])
        |=> !irqRequest)
        else $error("request raised with global enable clear");

    // Wake follows flag and comparator enable only
    a_wake_request: assert property (
        @(posedge core_clk) disable iff (rst)
        ce |=> wakeRequest == $past(st.compareChangeFlag &
                                    st.compareChangeEnable))
        else $error("wake request wrong");

    // Control register changes only by a write or by reset
    a_ctrl_kept: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && !(wrLane0 && regIdx == cmpc_pkg::IDX_COMP_CTRL))
        |=> $stable(st.compCtrl))
        else $error("control register changed without a write");

    // Latched copy moves only on a control register access
    a_latch_kept: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && !(commit && regIdx == cmpc_pkg::IDX_COMP_CTRL))
        |=> $stable(st.latchedResult))
        else $error("latched copy moved without an access");

    // Accepted result moves only when the last two stages agree
    a_sync_agree: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && st.aboveS2 != st.aboveS3) |=> $stable(st.aboveOk))
        else $error("result accepted before stages agreed");

    // Mode 000 keeps both comparators powered down
    a_reset_mode_off: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && modeField == cmpc_pkg::MODE_RESET)
        |=> compPowerDown == 2'h3)
        else $error("mode 000 left a comparator powered");

    // A powered-down comparator reads as zero
    a_off_reads_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        (ce && reqActive && st.waitReq && compPowerDown == 2'h3 &&
         regIdx == cmpc_pkg::IDX_COMP_CTRL)
        |=> busReadData[7:6] == 2'b00)
        else $error("powered-down comparator read nonzero");

    // Without inversion a routed pin is high when its input is above
    a_pin_polarity: assert property (
        @(posedge core_clk) disable iff (rst)
        (routeMode && invertBits == 2'b00) |-> portOut[4:3] == compAbove)
        else $error("routed pin polarity wrong");

endmodule

`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;

    logic                    core_clk;
    logic                    rst;
    logic                    ce;
    cmpc_pkg::cmpc_avm_req_t busReq;
    logic [31:0]             busReadData;
    logic                    busWaitRequest;
    logic [1:0]              compAbove;
    logic [1:0]              compPowerDown;
    logic [2:0]              compMode;
    logic                    compInputSwitch;
    logic [7:0]              portIn;
    logic [7:0]              portOut;
    logic [7:0]              portOutEnN;
    logic                    irqRequest;
    logic                    wakeRequest;
    int                      badCount;
    int                      comparisons;
    int                      cycles;
    logic [7:0]              maskTab [8];

    ////////////////////////////////////////////////////////////////////////
    // Clock and cycle ceiling
    always #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            badCount = badCount + 1;
            test_done();
        end
    end

    cmpc_comparator_ctrl u_dut (
        .core_clk        (core_clk),
        .rst             (rst),
        .ce              (ce),
        .busReq          (busReq),
        .busReadData     (busReadData),
        .busWaitRequest  (busWaitRequest),
        .compAbove       (compAbove),
        .compPowerDown   (compPowerDown),
        .compMode        (compMode),
        .compInputSwitch (compInputSwitch),
        .portIn          (portIn),
        .portOut         (portOut),
        .portOutEnN      (portOutEnN),
        .irqRequest      (irqRequest),
        .wakeRequest     (wakeRequest)
    );

    ////////////////////////////////////////////////////////////////////////
    // Verdict, compare and bus access
    task automatic test_done();
        if (badCount == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            badCount = badCount + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon access: hold until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] rdat);
        @(posedge core_clk);
        busReq <= '{address: {idx, 2'b00}, read: !wr, write: wr,
                    writedata: {24'h000000, wd}, byteenable: 4'h1};
        do begin
            @(posedge core_clk);
        end while (busWaitRequest !== 1'b0);
        rdat = busReadData[7:0];
        busReq <= '{default: '0};
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] dummy;
        bus(1'b1, idx, wd, dummy);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] got;
        bus(1'b0, idx, 8'h00, got);
        chk(got, exp);
    endtask

    task automatic settle();
        repeat (6) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        busReq = '{default: '0};
        compAbove = 2'b00;
        portIn = 8'hFF;
        maskTab = '{8'h0F, 8'h07, 8'h0F, 8'h07, 8'h0F, 8'h06, 8'h07, 8'h00};
        repeat (20) @(posedge core_clk);
        chk({6'h00, compPowerDown}, 8'h03);
        rst <= 1'b0;
        // Reset values of the register map
        rdchk(cmpc_pkg::IDX_COMP_CTRL, 8'h00);
        rdchk(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h00);
        rdchk(cmpc_pkg::IDX_PORT_A_DIR, 8'hFF);
        rdchk(cmpc_pkg::IDX_PERIPH_ENABLE, 8'h00);
        rdchk(8'h40, 8'h00);
        chk(portOutEnN, 8'hFF);
        // Port data reads mask the analog pins of every mode
        for (int m = 0; m < 8; m++) begin
            wr(cmpc_pkg::IDX_COMP_CTRL, 8'(m));
            settle();
            rdchk(cmpc_pkg::IDX_PORT_A_DATA, ~maskTab[m]);
            chk({5'h00, compMode}, 8'(m));
        end
        chk({6'h00, compPowerDown}, 8'h03);
        // Routed mode, bits 7:6 written high must not stick
        wr(cmpc_pkg::IDX_PORT_A_DIR, 8'hE7);
        wr(cmpc_pkg::IDX_COMP_CTRL, 8'hC6);
        settle();
        rdchk(cmpc_pkg::IDX_COMP_CTRL, 8'h06);
        wr(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h00);
        chk({6'h00, compPowerDown}, 8'h00);
        chk(portOutEnN, 8'hE7);
        wr(cmpc_pkg::IDX_PORT_A_DATA, 8'hFF);
        @(posedge core_clk);
        chk(portOut, 8'hE7);
        // First comparator goes high: flag sets with enables clear
        compAbove <= 2'b01;
        settle();
        chk({6'h00, portOut[4:3]}, 8'h01);
        rdchk(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h40);
        chk({7'h00, irqRequest}, 8'h00);
        // Clear while mismatch persists does not hold
        wr(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h00);
        rdchk(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h40);
        rdchk(cmpc_pkg::IDX_COMP_CTRL, 8'h46);
        wr(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h00);
        rdchk(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h00);
        // Enables and a simulated interrupt
        wr(cmpc_pkg::IDX_PERIPH_ENABLE, 8'hFF);
        rdchk(cmpc_pkg::IDX_PERIPH_ENABLE, 8'h40);
        wr(cmpc_pkg::IDX_CORE_INT_CTRL, 8'h40);
        wr(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h40);
        repeat (3) @(posedge core_clk);
        chk({7'h00, irqRequest}, 8'h00);
        chk({7'h00, wakeRequest}, 8'h01);
        wr(cmpc_pkg::IDX_CORE_INT_CTRL, 8'hC0);
        repeat (3) @(posedge core_clk);
        chk({7'h00, irqRequest}, 8'h01);
        wr(cmpc_pkg::IDX_PERIPH_ENABLE, 8'h00);
        repeat (3) @(posedge core_clk);
        chk({7'h00, irqRequest}, 8'h00);
        wr(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h00);
        // Clock enable low freezes capture and the flag
        ce <= 1'b0;
        compAbove <= 2'b11;
        repeat (10) @(posedge core_clk);
        ce <= 1'b1;
        rdchk(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h00);
        settle();
        rdchk(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h40);
        rdchk(cmpc_pkg::IDX_COMP_CTRL, 8'hC6);
        wr(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h00);
        // Invert the first result, second comparator high
        wr(cmpc_pkg::IDX_COMP_CTRL, 8'h16);
        compAbove <= 2'b11;
        settle();
        chk({6'h00, portOut[4:3]}, 8'h02);
        rdchk(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h40);
        rdchk(cmpc_pkg::IDX_COMP_CTRL, 8'h96);
        // Mode 001 with input switch
        wr(cmpc_pkg::IDX_COMP_CTRL, 8'h09);
        settle();
        chk({7'h00, compInputSwitch}, 8'h01);
        chk({6'h00, portOut[4:3]}, 8'h03);
        chk(portOut, 8'hFF);
        rdchk(cmpc_pkg::IDX_COMP_CTRL, 8'hC9);
        // Second reset in mid-run
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({6'h00, compPowerDown}, 8'h03);
        chk(portOut, 8'h00);
        rst <= 1'b0;
        rdchk(cmpc_pkg::IDX_COMP_CTRL, 8'h00);
        rdchk(cmpc_pkg::IDX_PORT_A_DIR, 8'hFF);
        rdchk(cmpc_pkg::IDX_PERIPH_FLAGS, 8'h00);
        test_done();
    end

endmodule

`default_nettype wire
